/* File: design/config_download_update_ctrl.sv */
/*
  Configuration loader: power-up download, staged or transparent updates, user reload,
  sequencing-state fetches and gating of host access to the nonvolatile array.
  Assumes a decoded byte-level host link on its own clock, an external nonvolatile
  array port on ref_clk_i, and engine/recorder status from logic on ref_clk_i.
*/
`timescale 1ns/1ns
`default_nettype none
module config_download_update_ctrl #(
  parameter int HOLD_CYCLES = cfg_loader_pkg::SE_HOLD_CYC
) (
  input  wire logic                      ref_clk_i,
  input  wire logic                      reset_n_i,
  input  wire logic                      supply_good_i,
  input  wire logic                      lnk_clk_i,
  input  wire logic                      lnk_cmd_valid_i,
  input  var  cfg_loader_pkg::host_cmd_t lnk_cmd_i,
  output logic                           lnk_busy_o,
  output logic                           lnk_resp_valid_o,
  output cfg_loader_pkg::host_resp_t     lnk_resp_o,
  output logic                           nvm_req_o,
  output cfg_loader_pkg::nv_op_t         nvm_op_o,
  output logic [9:0]                     nvm_addr_o,
  output logic [7:0]                     nvm_wdata_o,
  input  wire logic                      nvm_done_i,
  input  wire logic [7:0]                nvm_rdata_i,
  input  wire logic                      se_running_i,
  input  wire logic                      se_next_i,
  input  wire logic [5:0]                se_next_idx_i,
  output logic [63:0]                    se_word_o,
  output logic                           se_word_valid_o,
  input  wire logic                      fr_enabled_i,
  input  wire logic                      fr_trigger_any_i,
  input  wire logic [7:0]                cfg_sel_i,
  output logic [7:0]                     cfg_o,
  output logic                           cfg_ready_o
);
  import cfg_loader_pkg::*;

  // ----------------------------------------------------------------
  // link domain: pointer, request toggle, answer pick-up
  // ----------------------------------------------------------------
  logic        lrst1, lrst2, lnk_rst_n, ans1, ans2, ans3, ans_tog;
  logic        req_tog, next_req_tog, next_busy, next_rv;
  logic [15:0] ptr, next_ptr;
  host_req_t   req_q, next_req;
  host_resp_t  next_lresp, core_resp;

  assign lnk_rst_n = lrst2;
  always_comb begin
    next_ptr     = ptr;
    next_req     = req_q;
    next_req_tog = req_tog;
    next_busy    = lnk_busy_o;
    next_rv      = 1'b0;
    next_lresp   = lnk_resp_o;
    // pointer bytes are local; only one request is outstanding at a time
    if (lnk_cmd_valid_i && !lnk_busy_o) begin
      unique case (lnk_cmd_i.kind)
        K_PTR_LO: next_ptr = {8'h00, lnk_cmd_i.data};
        K_PTR_HI: next_ptr[15:8] = lnk_cmd_i.data;
        default: begin
          next_req     = '{kind: lnk_cmd_i.kind, addr: ptr, data: lnk_cmd_i.data};
          next_req_tog = ~req_tog;
          next_busy    = 1'b1;
        end
      endcase
    end
    // answer word is held stable by the core until the next request
    if (lnk_busy_o && (ans2 != ans3)) begin
      next_busy  = 1'b0;
      next_rv    = 1'b1;
      next_lresp = core_resp;
    end
  end

  always_ff @(posedge lnk_clk_i) begin
    lrst1 <= reset_n_i;
    lrst2 <= lrst1;
    ans1  <= ans_tog;
    ans2  <= ans1;
    ans3  <= ans2;
    if (!lnk_rst_n) begin
      ptr              <= 16'h0000;
      req_q            <= '{kind: K_READ, addr: 16'h0000, data: 8'h00};
      req_tog          <= 1'b0;
      lnk_busy_o       <= 1'b0;
      lnk_resp_valid_o <= 1'b0;
      lnk_resp_o       <= '{ack: 1'b0, rdata: 8'h00};
    end else begin
      ptr              <= next_ptr;
      req_q            <= next_req;
      req_tog          <= next_req_tog;
      lnk_busy_o       <= next_busy;
      lnk_resp_valid_o <= next_rv;
      lnk_resp_o       <= next_lresp;
    end
  end

  // ----------------------------------------------------------------
  // core domain
  // ----------------------------------------------------------------
  load_state_t st, next_st;
  logic [7:0]  lat_a [CFG_BYTES];
  logic [7:0]  lat_b [CFG_BYTES];
  logic [7:0]  next_a [CFG_BYTES];
  logic [7:0]  next_b [CFG_BYTES];
  logic [7:0]  idx, next_idx, baddr, next_baddr, update_configuration_control, next_update_configuration_control, next_nwd, next_cfgo;
  logic [31:0] hold, next_hold;
  logic        bpend, next_bpend, user_go, next_user_go, se_pend, next_se_pend;
  logic        pend, next_pend, next_ans_tog, next_nvreq, next_se_valid, next_boot;
  logic [5:0]  se_idx, next_se_idx;
  host_req_t   hreq, next_hreq;
  host_resp_t  next_cresp;
  nv_op_t      next_nvop;
  logic [9:0]  next_naddr;
  logic [63:0] next_se_word;
  logic        sup1, sup2, rq1, rq2, rq3;
  logic        new_req;
  assign new_req = rq2 ^ rq3;
  function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo,
                                  input logic [15:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction
  always_comb begin
    logic       do_resp;
    host_resp_t rsp;
    logic       fr_act;
    logic       in_nv;
    do_resp       = 1'b0;
    rsp           = '{ack: 1'b0, rdata: 8'h00};
    fr_act        = fr_enabled_i && fr_trigger_any_i;
    in_nv         = in_rng(hreq.addr, NV_LO, NV_SE_HI);
    next_st       = st;
    next_a        = lat_a;
    next_b        = lat_b;
    next_idx      = idx;
    next_hold     = hold;
    next_bpend    = 1'b0;
    next_baddr    = baddr;
    next_update_configuration_control   = update_configuration_control;
    next_user_go  = user_go;
    next_se_pend  = se_pend | se_next_i;
    next_se_idx   = se_next_i ? se_next_idx_i : se_idx;
    next_pend     = pend | new_req;
    next_hreq     = new_req ? req_q : hreq;
    next_cresp    = core_resp;
    next_ans_tog  = ans_tog;
    next_nvreq    = nvm_req_o;
    next_nvop     = nvm_op_o;
    next_naddr    = nvm_addr_o;
    next_nwd      = nvm_wdata_o;
    next_se_word  = se_word_o;
    next_se_valid = 1'b0;
    next_boot     = cfg_ready_o;
    next_cfgo     = (cfg_sel_i < CFG_BYTES) ? lat_b[cfg_sel_i] : 8'h00;
    // second side follows one cycle after the first
    if (bpend) next_b[baddr] = lat_a[baddr];
    unique case (st)
      ST_OFF: begin
        if (sup2) begin
          next_st  = ST_LOAD;
          next_idx = 8'h00;
        end
      end
      ST_LOAD: begin
        // only pages zero to four are loaded, reserved pages stay untouched
        if (nvm_req_o && nvm_done_i) begin
          next_nvreq       = 1'b0;
          next_a[idx]      = nvm_rdata_i;
          next_idx         = idx + 8'h01;
          if (idx == CFG_LAST) next_st = ST_XFER;
        end else if (!nvm_req_o) begin
          next_nvreq = 1'b1;
          next_nvop  = NV_READ;
          next_naddr = {2'b00, idx};
        end
      end
      ST_XFER: begin
        next_b    = lat_a;
        next_boot = 1'b1;
        next_hold = 32'h0000_0000;
        next_st   = cfg_ready_o ? ST_READY : ST_HOLD;
      end
      ST_HOLD: begin
        next_hold = hold + 32'h0000_0001;
        if (hold == 32'(HOLD_CYCLES - 1)) begin
          next_st     = ST_SEFETCH;
          next_idx    = 8'h00;
          next_se_idx = 6'h00;
        end
      end
      ST_SEFETCH: begin
        // one word is eight bytes, most significant first
        if (nvm_req_o && nvm_done_i) begin
          next_nvreq   = 1'b0;
          next_se_word = {se_word_o[55:0], nvm_rdata_i};
          next_idx     = idx + 8'h01;
          if (idx[2:0] == SE_LAST_BYTE) begin
            next_se_valid = 1'b1;
            next_st       = ST_READY;
          end
        end else if (!nvm_req_o) begin
          next_nvreq = 1'b1;
          next_nvop  = NV_READ;
          next_naddr = NV_SE_OFS + {1'b0, se_idx, idx[2:0]};
        end
      end
      ST_READY: begin
        if (user_go) begin
          next_user_go = 1'b0;
          next_st      = ST_LOAD;
          next_idx     = 8'h00;
        end else if (se_pend) begin
          next_se_pend = se_next_i;
          next_st      = ST_SEFETCH;
          next_idx     = 8'h00;
        end else if (pend) begin
          if (in_nv) begin
            if (in_rng(hreq.addr, NV_SE_LO, NV_SE_HI) && se_running_i) begin
              do_resp = 1'b1;
            end else if (fr_act && (in_rng(hreq.addr, NV_LO, NV_CFG_HI) ||
                                    in_rng(hreq.addr, NV_USER_LO, NV_USER_HI))) begin
              do_resp = 1'b1;
              rsp.ack = 1'b1;
            end else if (hreq.kind == K_CMD && !(hreq.data == ERASE_CODE &&
                                                 update_configuration_control[UPD_ERASE_BIT])) begin
              do_resp = 1'b1;
              rsp.ack = 1'b1;
            end else begin
              // pages five to seven are plain storage here
              next_nvreq = 1'b1;
              next_naddr = hreq.addr[9:0];
              next_nwd   = hreq.data;
              next_st    = ST_HOSTNV;
              unique case (hreq.kind)
                K_WRITE: next_nvop = NV_WRITE;
                K_CMD:   next_nvop = NV_ERASE;
                default: next_nvop = NV_READ;
              endcase
            end
          end else if (hreq.addr[15:8] == 8'h00) begin
            do_resp = 1'b1;
            rsp.ack = 1'b1;
            if (hreq.kind == K_WRITE) begin
              if (hreq.addr[7:0] == UPDATE_CONFIGURATION_CONTROL_ADDR) begin
                next_update_configuration_control = hreq.data & 8'h05;
                if (hreq.data[UPD_COMMIT_BIT]) next_b = lat_a;
              end else if (hreq.addr[7:0] == UDL_ADDR) begin
                next_user_go = hreq.data[UDL_GO_BIT];
              end else if (hreq.addr[7:0] <= CFG_LAST) begin
                next_a[hreq.addr[7:0]] = hreq.data;
                next_bpend = update_configuration_control[UPD_OPEN_BIT];
                next_baddr = hreq.addr[7:0];
              end
            end else if (hreq.addr[7:0] == UPDATE_CONFIGURATION_CONTROL_ADDR) begin
              rsp.rdata = update_configuration_control;
            end else if (hreq.addr[7:0] <= CFG_LAST) begin
              rsp.rdata = lat_a[hreq.addr[7:0]];
            end
          end else begin
            do_resp = 1'b1;
          end
        end
      end
      ST_HOSTNV: begin
        if (nvm_done_i) begin
          next_nvreq = 1'b0;
          do_resp    = 1'b1;
          rsp        = '{ack: 1'b1, rdata: (hreq.kind == K_READ) ? nvm_rdata_i : 8'h00};
          next_st    = ST_READY;
        end
      end
      default: next_st = ST_OFF;
    endcase
    // before the first download is over every request is refused
    if (!cfg_ready_o && pend) begin
      do_resp = 1'b1;
      rsp     = '{ack: 1'b0, rdata: 8'h00};
    end
    if (do_resp) begin
      next_cresp   = rsp;
      next_ans_tog = ~ans_tog;
      next_pend    = new_req;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    sup1 <= supply_good_i;
    sup2 <= sup1;
    rq1  <= req_tog;
    rq2  <= rq1;
    rq3  <= rq2;
    // latches are not reset: the download always fills them
    lat_a <= next_a;
    lat_b <= next_b;
    if (!reset_n_i) begin
      st              <= ST_OFF;
      idx             <= 8'h00;
      hold            <= 32'h0000_0000;
      bpend           <= 1'b0;
      baddr           <= 8'h00;
      update_configuration_control          <= UPDATE_CONFIGURATION_CONTROL_RESET;
      user_go         <= 1'b0;
      se_pend         <= 1'b0;
      se_idx          <= 6'h00;
      pend            <= 1'b0;
      hreq            <= '{kind: K_READ, addr: 16'h0000, data: 8'h00};
      core_resp       <= '{ack: 1'b0, rdata: 8'h00};
      ans_tog         <= 1'b0;
      nvm_req_o       <= 1'b0;
      nvm_op_o        <= NV_READ;
      nvm_addr_o      <= 10'h000;
      nvm_wdata_o     <= 8'h00;
      se_word_o       <= 64'h0000_0000_0000_0000;
      se_word_valid_o <= 1'b0;
      cfg_ready_o     <= 1'b0;
      cfg_o           <= 8'h00;
    end else begin
      st              <= next_st;
      idx             <= next_idx;
      hold            <= next_hold;
      bpend           <= next_bpend;
      baddr           <= next_baddr;
      update_configuration_control          <= next_update_configuration_control;
      user_go         <= next_user_go;
      se_pend         <= next_se_pend;
      se_idx          <= next_se_idx;
      pend            <= next_pend;
      hreq            <= next_hreq;
      core_resp       <= next_cresp;
      ans_tog         <= next_ans_tog;
      nvm_req_o       <= next_nvreq;
      nvm_op_o        <= next_nvop;
      nvm_addr_o      <= next_naddr;
      nvm_wdata_o     <= next_nwd;
      se_word_o       <= next_se_word;
      se_word_valid_o <= next_se_valid;
      cfg_ready_o     <= next_boot;
      cfg_o           <= next_cfgo;
    end
  end
endmodule
`default_nettype wire

/* File: design/cfg_loader_pkg.sv */
/*
  Shared constants and types for the configuration download and update controller.
  Assumes a 20 MHz reference clock and a nonvolatile array port that answers one
  operation at a time with a done pulse.
*/
`default_nettype none
package cfg_loader_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam real REF_CLK_PERIOD_NS = 50.0;
  localparam real SE_HOLD_MS        = 0.5;
  // least time, so round up
  localparam int  SE_HOLD_CYC       = int'($ceil(SE_HOLD_MS * 1.0e6 / REF_CLK_PERIOD_NS));

  // ----------------------------------------------------------------
  // volatile map
  // ----------------------------------------------------------------
  localparam int        CFG_BYTES     = 160;
  localparam logic [7:0] CFG_LAST     = 8'h9f;
  localparam logic [7:0] UPDATE_CONFIGURATION_CONTROL_ADDR  = 8'h90;
  localparam logic [7:0] UDL_ADDR     = 8'hd8;
  localparam int        UPD_OPEN_BIT  = 0;
  localparam int        UPD_COMMIT_BIT = 1;
  localparam int        UPD_ERASE_BIT = 2;
  localparam int        UDL_GO_BIT    = 0;
  localparam logic [7:0] UPDATE_CONFIGURATION_CONTROL_RESET = 8'h00;
  localparam logic [7:0] ERASE_CODE   = 8'hfe;

  // ----------------------------------------------------------------
  // nonvolatile map
  // ----------------------------------------------------------------
  localparam logic [15:0] NV_LO      = 16'hf800;
  localparam logic [15:0] NV_CFG_HI  = 16'hf89f;
  localparam logic [15:0] NV_USER_LO = 16'hf900;
  localparam logic [15:0] NV_USER_HI = 16'hf9ff;
  localparam logic [15:0] NV_SE_LO   = 16'hfa00;
  localparam logic [15:0] NV_SE_HI   = 16'hfbff;
  localparam logic [9:0]  NV_SE_OFS  = 10'h200;
  localparam logic [2:0]  SE_LAST_BYTE = 3'h7;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OFF     = 3'b000,
    ST_LOAD    = 3'b001,
    ST_XFER    = 3'b011,
    ST_HOLD    = 3'b010,
    ST_SEFETCH = 3'b110,
    ST_READY   = 3'b111,
    ST_HOSTNV  = 3'b101
  } load_state_t;

  typedef enum logic [2:0] {
    K_PTR_LO = 3'h0,
    K_PTR_HI = 3'h1,
    K_WRITE  = 3'h2,
    K_READ   = 3'h3,
    K_CMD    = 3'h4
  } req_kind_t;

  typedef enum logic [1:0] {
    NV_READ  = 2'h0,
    NV_WRITE = 2'h1,
    NV_ERASE = 2'h2
  } nv_op_t;

  typedef struct packed {
    req_kind_t  kind;
    logic [7:0] data;
  } host_cmd_t;

  typedef struct packed {
    req_kind_t   kind;
    logic [15:0] addr;
    logic [7:0]  data;
  } host_req_t;

  typedef struct packed {
    logic       ack;
    logic [7:0] rdata;
  } host_resp_t;
endpackage
`default_nettype wire

/* File: bench/cfg_loader_props.sv */
/*
  Concurrent checks on the configuration loader's ports.
  Assumes the loader's own port names; attached by bind below.
*/
`timescale 1ns/1ns
`default_nettype none
module cfg_loader_props #(
  parameter int HOLD_CYCLES = cfg_loader_pkg::SE_HOLD_CYC
) (
  input wire logic                        ref_clk_i,
  input wire logic                        reset_n_i,
  input wire logic                        supply_good_i,
  input wire logic                        lnk_clk_i,
  input wire logic                        lnk_busy_o,
  input wire logic                        lnk_resp_valid_o,
  input var  cfg_loader_pkg::host_resp_t  lnk_resp_o,
  input wire logic                        nvm_req_o,
  input var  cfg_loader_pkg::nv_op_t      nvm_op_o,
  input wire logic [9:0]                  nvm_addr_o,
  input wire logic                        nvm_done_i,
  input wire logic                        se_next_i,
  input wire logic                        se_word_valid_o,
  input wire logic                        cfg_ready_o
);
  import cfg_loader_pkg::*;
  // ----------------------------------------------------------------
  // cycles since download finished
  // ----------------------------------------------------------------
  logic [15:0] since_ready;
  logic [15:0] next_since_ready;
  always_comb begin
    next_since_ready = since_ready;
    if (!reset_n_i || !cfg_ready_o) next_since_ready = 16'h0000;
    else if (since_ready != 16'hffff) next_since_ready = since_ready + 16'h0001;
  end
  always_ff @(posedge ref_clk_i) begin
    since_ready <= next_since_ready;
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_nack;
    @(posedge lnk_clk_i) disable iff (!reset_n_i)
      lnk_resp_valid_o && !cfg_ready_o |-> !lnk_resp_o.ack;
  endproperty
  property p_busy;
    @(posedge lnk_clk_i) disable iff (!reset_n_i) $fell(lnk_busy_o) |-> lnk_resp_valid_o;
  endproperty
  property p_ready_stays;
    @(posedge ref_clk_i) disable iff (!reset_n_i) cfg_ready_o |=> cfg_ready_o;
  endproperty
  property p_supply;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      $rose(nvm_req_o) && !cfg_ready_o |-> $past(supply_good_i, 2);
  endproperty
  property p_dl_reads;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      nvm_req_o && !cfg_ready_o |-> nvm_op_o == NV_READ && nvm_addr_o <= 10'h09f;
  endproperty
  // one cycle of slack for where the hold counter starts
  property p_hold;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      cfg_ready_o && int'(since_ready) < HOLD_CYCLES - 1 |-> !nvm_req_o;
  endproperty
  property p_first_fetch;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      $rose(cfg_ready_o) |-> ##[1:1000] se_word_valid_o;
  endproperty
  property p_next_fetch;
    @(posedge ref_clk_i) disable iff (!reset_n_i) $rose(se_next_i) |-> ##[1:200] se_word_valid_o;
  endproperty
  property p_req_held;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      nvm_req_o && !nvm_done_i |=> nvm_req_o && $stable(nvm_addr_o) && $stable(nvm_op_o);
  endproperty
  a_nack: assert property (p_nack) else $error("answer acked before download");
  a_busy: assert property (p_busy) else $error("busy dropped without answer");
  a_ready_stays: assert property (p_ready_stays) else $error("ready dropped");
  a_supply: assert property (p_supply) else $error("download without supply");
  a_dl_reads: assert property (p_dl_reads) else $error("bad download access");
  a_hold: assert property (p_hold) else $error("state fetch too early");
  a_first_fetch: assert property (p_first_fetch) else $error("no first state");
  a_next_fetch: assert property (p_next_fetch) else $error("no next state");
  a_req_held: assert property (p_req_held) else $error("array request changed");
  c_ready: cover property (@(posedge ref_clk_i) $rose(cfg_ready_o));
  c_word: cover property (@(posedge ref_clk_i) se_word_valid_o);
  c_nack: cover property (@(posedge lnk_clk_i) lnk_resp_valid_o && !lnk_resp_o.ack);
endmodule
bind config_download_update_ctrl cfg_loader_props #(.HOLD_CYCLES(HOLD_CYCLES)) u_props (
  .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .supply_good_i(supply_good_i),
  .lnk_clk_i(lnk_clk_i), .lnk_busy_o(lnk_busy_o), .lnk_resp_valid_o(lnk_resp_valid_o),
  .lnk_resp_o(lnk_resp_o), .nvm_req_o(nvm_req_o), .nvm_op_o(nvm_op_o),
  .nvm_addr_o(nvm_addr_o), .nvm_done_i(nvm_done_i), .se_next_i(se_next_i),
  .se_word_valid_o(se_word_valid_o), .cfg_ready_o(cfg_ready_o));
`default_nettype wire

/* File: bench/host_link_model.sv */
/*
  Host side of the byte link: pointer bytes then one request, one outstanding.
  Assumes a free running link clock; inputs change on its falling edge.
*/
`timescale 1ns/1ns
`default_nettype none
module host_link_model (
  input  wire logic                       lnk_clk_i,
  input  wire logic                       lnk_resp_valid_i,
  input  var  cfg_loader_pkg::host_resp_t lnk_resp_i,
  output logic                            lnk_cmd_valid_o,
  output cfg_loader_pkg::host_cmd_t       lnk_cmd_o
);
  import cfg_loader_pkg::*;
  initial begin
    lnk_cmd_valid_o = 1'b0;
    lnk_cmd_o = '0;
  end
  task automatic send(input req_kind_t k, input logic [7:0] d);
    @(negedge lnk_clk_i);
    lnk_cmd_valid_o = 1'b1;
    lnk_cmd_o = '{kind: k, data: d};
    @(negedge lnk_clk_i);
    lnk_cmd_valid_o = 1'b0;
    // released byte does not keep its value
    lnk_cmd_o = '{kind: k, data: ~d};
  endtask
  // only the pointer selects the place; no auto-increment is relied on
  task automatic access(input logic [15:0] a, input req_kind_t k, input logic [7:0] d,
                        output logic ack, output logic [7:0] rd);
    int n;
    send(K_PTR_LO, a[7:0]);
    send(K_PTR_HI, a[15:8]);
    send(k, d);
    n = 0;
    while (!lnk_resp_valid_i && n < 20000) begin
      @(negedge lnk_clk_i);
      n++;
    end
    ack = (n < 20000) ? lnk_resp_i.ack : 1'bx;
    rd = (n < 20000) ? lnk_resp_i.rdata : 8'hxx;
  endtask
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
/*
  Self-checking bench for the configuration loader with a host link model
  and a behavioural nonvolatile array.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import cfg_loader_pkg::*;
  logic ref_clk, lnk_clk, reset_n, supply_good, se_running, se_next, fr_en, fr_trig;
  logic lnk_valid, busy, resp_valid, nvm_req, nvm_done, se_valid, cfg_ready, ack;
  logic [7:0] nvm_rdata, nvm_wdata, cfg_sel, cfg, rd, keep;
  logic [5:0] se_idx;
  logic [9:0] nvm_addr;
  logic [63:0] se_word;
  host_cmd_t cmd;
  host_resp_t resp;
  nv_op_t nvm_op;
  logic [7:0] mem [0:1023];
  int err_count, cmp_count;
  config_download_update_ctrl #(.HOLD_CYCLES(20)) uut (
    .ref_clk_i(ref_clk), .reset_n_i(reset_n), .supply_good_i(supply_good),
    .lnk_clk_i(lnk_clk), .lnk_cmd_valid_i(lnk_valid), .lnk_cmd_i(cmd), .lnk_busy_o(busy),
    .lnk_resp_valid_o(resp_valid), .lnk_resp_o(resp), .nvm_req_o(nvm_req),
    .nvm_op_o(nvm_op), .nvm_addr_o(nvm_addr), .nvm_wdata_o(nvm_wdata),
    .nvm_done_i(nvm_done), .nvm_rdata_i(nvm_rdata), .se_running_i(se_running),
    .se_next_i(se_next), .se_next_idx_i(se_idx), .se_word_o(se_word),
    .se_word_valid_o(se_valid), .fr_enabled_i(fr_en), .fr_trigger_any_i(fr_trig),
    .cfg_sel_i(cfg_sel), .cfg_o(cfg), .cfg_ready_o(cfg_ready));
  host_link_model host (.lnk_clk_i(lnk_clk), .lnk_resp_valid_i(resp_valid),
    .lnk_resp_i(resp), .lnk_cmd_valid_o(lnk_valid), .lnk_cmd_o(cmd));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    lnk_clk = 1'b0;
    #7;
    forever #3 lnk_clk = ~lnk_clk;
  end
  // ----------------------------------------------------------------
  // nonvolatile array: one-cycle done, data only valid with done
  // ----------------------------------------------------------------
  always @(negedge ref_clk) begin
    nvm_done <= 1'b0;
    nvm_rdata <= ~nvm_rdata;
    if (nvm_req && !nvm_done) begin
      nvm_done <= 1'b1;
      nvm_rdata <= mem[nvm_addr];
      if (nvm_op == NV_WRITE) mem[nvm_addr] <= nvm_wdata;
      if (nvm_op == NV_ERASE) for (int i = 0; i < 32; i++) mem[{nvm_addr[9:5], 5'(i)}] <= 8'hff;
    end
  end
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic acc(input logic [15:0] a, input req_kind_t k, input logic [7:0] d);
    host.access(a, k, d, ack, rd);
  endtask
  task automatic cfgchk(input logic [7:0] s, input logic [7:0] e);
    @(negedge ref_clk);
    cfg_sel = s;
    repeat (4) @(negedge ref_clk);
    check(64'(cfg), 64'(e));
  endtask
  task automatic wait_se;
    for (int n = 0; n < 2000 && !se_valid; n++) @(negedge ref_clk);
  endtask
  function automatic logic [63:0] seword(input int base);
    logic [63:0] w;
    for (int i = 0; i < 8; i++) w[63 - 8 * i -: 8] = mem[base + i];
    return w;
  endfunction
  initial begin
    repeat (60000) @(posedge ref_clk);
    err_count++;
    $display("Error at %0t: watchdog expired", $time);
    results;
  end
  initial begin
    {reset_n, supply_good, se_running, se_next, fr_en, fr_trig} = '0;
    {se_idx, cfg_sel, err_count, cmp_count} = '0;
    for (int i = 0; i < 1024; i++) mem[i] = 8'(i * 7 + 3);
    repeat (16) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    acc(16'h0010, K_READ, 8'h00);
    check(64'(ack), 64'h0);
    supply_good = 1'b1;
    for (int n = 0; n < 2000 && !cfg_ready; n++) @(negedge ref_clk);
    check(64'(cfg_ready), 64'h1);
    wait_se;
    check(se_word, seword(16'h200));
    cfgchk(8'h10, mem[16'h10]);
    cfgchk(8'h9f, mem[16'h9f]);
    acc(16'h0090, K_WRITE, 8'h00);
    acc(16'h0010, K_WRITE, 8'ha5);
    acc(16'h0010, K_READ, 8'h00);
    check(64'(rd), 64'ha5);
    cfgchk(8'h10, mem[16'h10]);
    acc(16'h0090, K_WRITE, 8'h02);
    cfgchk(8'h10, 8'ha5);
    acc(16'h0090, K_WRITE, 8'h01);
    acc(16'h0011, K_WRITE, 8'h3c);
    cfgchk(8'h11, 8'h3c);
    acc(16'h00d8, K_WRITE, 8'h01);
    acc(16'h0010, K_READ, 8'h00);
    check(64'(rd), 64'(mem[16'h10]));
    cfgchk(8'h11, mem[16'h11]);
    acc(16'h0100, K_READ, 8'h00);
    check(64'(ack), 64'h0);
    acc(16'hfc00, K_READ, 8'h00);
    check(64'(ack), 64'h0);
    @(negedge ref_clk);
    se_running = 1'b1;
    acc(16'hfa00, K_READ, 8'h00);
    check(64'(ack), 64'h0);
    @(negedge ref_clk);
    se_running = 1'b0;
    acc(16'hfa00, K_READ, 8'h00);
    check({ack, rd}, {1'b1, mem[16'h200]});
    @(negedge ref_clk);
    {fr_en, fr_trig} = 2'b11;
    keep = mem[16'h100];
    acc(16'hf810, K_READ, 8'h00);
    check({ack, rd}, {1'b1, 8'h00});
    acc(16'hf900, K_WRITE, 8'h77);
    check({ack, mem[16'h100]}, {1'b1, keep});
    @(negedge ref_clk);
    fr_trig = 1'b0;
    acc(16'hf810, K_READ, 8'h00);
    check(64'(rd), 64'(mem[16'h10]));
    @(negedge ref_clk);
    fr_en = 1'b0;
    acc(16'h0090, K_WRITE, 8'h00);
    keep = mem[16'h1e0];
    acc(16'hf9e0, K_CMD, ERASE_CODE);
    check(64'(mem[16'h1e0]), 64'(keep));
    acc(16'h0090, K_WRITE, 8'h06);
    acc(16'h0090, K_READ, 8'h00);
    check(64'(rd), 64'h04);
    keep = mem[16'h1c0];
    acc(16'hf9c0, K_CMD, 8'hfd);
    check(64'(mem[16'h1c0]), 64'(keep));
    acc(16'hf9e0, K_CMD, ERASE_CODE);
    check({mem[16'h1e0], mem[16'h1ff]}, 16'hffff);
    acc(16'hf9e5, K_WRITE, 8'h12);
    check(64'(mem[16'h1e5]), 64'h12);
    acc(16'hfa00, K_CMD, ERASE_CODE);
    acc(16'hfa08, K_WRITE, 8'h5a);
    check(64'(mem[16'h208]), 64'h5a);
    @(negedge ref_clk);
    se_idx = 6'd1;
    se_next = 1'b1;
    @(negedge ref_clk);
    se_next = 1'b0;
    wait_se;
    check(se_word, 64'h5aff_ffff_ffff_ffff);
    results;
  end
endmodule
`default_nettype wire
